/* File: inc/sscr_consts.svh */
`ifndef SSCR_CONSTS_SVH
`define SSCR_CONSTS_SVH
// shift register
`define SSCR_WORD_W 24
// address codes (low bits of a loaded word)
`define SSCR_ADR0 2'b00
`define SSCR_ADR1 2'b01
`define SSCR_ADR2 2'b10
`define SSCR_ADR3 3'b011
`define SSCR_ADR4 4'b0111
`define SSCR_ADR5 5'b01111
`define SSCR_ADR6 6'b011111
// R0 fields
`define SSCR_R0_BUILTIN 23
// R1 fields
`define SSCR_R1_AUXF_HI 23
`define SSCR_R1_AUXF_LO 22
`define SSCR_R1_REFSEL 21
`define SSCR_R1_SPUR_HI 12
`define SSCR_R1_SPUR_LO 11
`define SSCR_R1_OBP_HI 5
`define SSCR_R1_OBP_LO 4
`define SSCR_R1_SYNTH 3
`define SSCR_R1_AUX 2
// R2 fields
`define SSCR_R2_PUMP_HI 23
`define SSCR_R2_PUMP_LO 22
// R3 fields
`define SSCR_R3_DUR_HI 23
`define SSCR_R3_DUR_LO 22
`define SSCR_R3_THR_HI 21
`define SSCR_R3_THR_LO 20
`define SSCR_R3_BOOST 19
`define SSCR_R3_OSC_HI 5
`define SSCR_R3_OSC_LO 4
// R4 fields
`define SSCR_R4_SWAL_HI 16
`define SSCR_R4_SWAL_LO 13
`define SSCR_R4_MAIN_HI 12
`define SSCR_R4_MAIN_LO 4
// R5 fields
`define SSCR_R5_REF_HI 13
`define SSCR_R5_REF_LO 5
// spur scheme codes
`define SSCR_SPUR_OFF 2'b00
`define SSCR_SPUR_TRACK 2'b10
`define SSCR_SPUR_ONCE 2'b11
// built-in divider defaults (arbitrary plain values)
`define SSCR_DEF_SWAL 4'h0
`define SSCR_DEF_MAIN 9'h010
`define SSCR_DEF_REF 9'h002
// reset values of the clk-domain mirror
`define SSCR_Z24 24'h000000
`define SSCR_MUL16 4
`endif

/* File: inc/sscr_pkg.sv */
package sscr_pkg;
    typedef enum logic [2:0] {
        SSCR_SP_OFF = 3'b001,
        SSCR_SP_TRACK = 3'b010,
        SSCR_SP_FROZEN = 3'b100
    } sscr_spur_t;
endpackage

/* File: design/sscr_regs.sv */
`include "sscr_consts.svh"
// Notes on behaviour
// - spur field picks off, tracking, once
// - once mode freezes compensation at lock
// - output power code drives buffer level
// - separate synth and aux enable bits
// - chip enable low turns off synth, aux and boost only
// - two bits select default aux frequency
// - one bit selects reference rate
// - low bits 10 load R2
// - two bits select aux pump current
// - low bits 011 load R3
// - boost duration code passed out
// - boost phase threshold code passed out
// - boost enable bit gates controller
// - oscillator drive current code passed out
// - low bits 0111 load R4 dividers
// - builtin bit selects default dividers
// - division equals sixteen main plus swallow
// - low bits 01111 load R5
// - reference divider nine bits wide
// - low bits 011111 load R6
// - msb first shift, load on strobe rise
// - low bits 00 load R0
module sscr_regs
(
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // serial link, own clock domain
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic latch_strobe_i,
    // pins and status
    input wire logic chip_en_i,
    input wire logic pll_locked_i,
    // decoded controls
    output logic synth_active_o,
    output logic aux_active_o,
    output logic [1:0] out_buffer_power_o,
    output logic [1:0] default_aux_freq_select_o,
    output logic reference_rate_select_o,
    output logic [1:0] aux_pump_current_o,
    output logic [1:0] boost_duration_o,
    output logic [1:0] boost_phase_threshold_o,
    output logic boost_active_o,
    output logic [1:0] oscillator_drive_current_o,
    output sscr_pkg::sscr_spur_t spur_mode_o,
    output logic spur_adapt_o,
    output logic [12:0] aux_feedback_div_o,
    output logic [8:0] aux_ref_div_o,
    output logic [23:0] factory_test_o
);
    import sscr_pkg::*;

    //////////////////////////////////////////////////////////////////////
    // serial domain: shifter and word registers, no reset by design

    logic [23:0] shift_reg;
    logic [23:0] r0_reg;
    logic [23:0] r1_reg;
    logic [23:0] r2_reg;
    logic [23:0] r3_reg;
    logic [23:0] r4_reg;
    logic [23:0] r5_reg;
    logic [23:0] r6_reg;
    logic load_tgl_reg;
    logic le_q_reg;

    always_ff @(posedge ser_clk_i)
    begin
        shift_reg <= {shift_reg[`SSCR_WORD_W-2:0], ser_data_i};
    end

    // strobe sampled on the link clock so the rise is seen in-domain
    always_ff @(posedge ser_clk_i)
    begin
        le_q_reg <= latch_strobe_i;
    end

    always_ff @(posedge ser_clk_i)
    begin
        if (latch_strobe_i && !le_q_reg)
        begin
            if (shift_reg[1:0] == `SSCR_ADR0)
                r0_reg <= shift_reg;
            else if (shift_reg[1:0] == `SSCR_ADR1)
                r1_reg <= shift_reg;
            else if (shift_reg[1:0] == `SSCR_ADR2)
                r2_reg <= shift_reg;
            else if (shift_reg[2:0] == `SSCR_ADR3)
                r3_reg <= shift_reg;
            else if (shift_reg[3:0] == `SSCR_ADR4)
                r4_reg <= shift_reg;
            else if (shift_reg[4:0] == `SSCR_ADR5)
                r5_reg <= shift_reg;
            else if (shift_reg[5:0] == `SSCR_ADR6)
                r6_reg <= shift_reg;
        end
    end

    // toggle needs a known start or the crossing never fires; only
    // this flop is reset, link clock stands still while rst_i is high
    always_ff @(posedge ser_clk_i or posedge rst_i)
    begin
        if (rst_i)
            load_tgl_reg <= 1'b0;
        else if (latch_strobe_i && !le_q_reg)
            load_tgl_reg <= ~load_tgl_reg;
    end

    //////////////////////////////////////////////////////////////////////
    // crossing: toggle sync, then copy the stable words

    logic [2:0] tgl_sync_reg;
    logic [1:0] ce_sync_reg;
    logic [1:0] lock_sync_reg;
    logic lock_d_reg;
    logic [23:0] m0_reg;
    logic [23:0] m1_reg;
    logic [23:0] m2_reg;
    logic [23:0] m3_reg;
    logic [23:0] m4_reg;
    logic [23:0] m5_reg;
    logic [23:0] m6_reg;
    logic take;

    // words are stable for many link edges after a toggle, so a
    // synced toggle makes a safe capture; host must not reload within
    // a few system clocks
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            tgl_sync_reg <= 3'h0;
        else
            tgl_sync_reg <= {tgl_sync_reg[1:0], load_tgl_reg};
    end

    assign take = tgl_sync_reg[2] ^ tgl_sync_reg[1];

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ce_sync_reg <= 2'h0;
            lock_sync_reg <= 2'h0;
            lock_d_reg <= 1'b0;
        end
        else
        begin
            ce_sync_reg <= {ce_sync_reg[0], chip_en_i};
            lock_sync_reg <= {lock_sync_reg[0], pll_locked_i};
            lock_d_reg <= lock_sync_reg[1];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            m0_reg <= `SSCR_Z24;
            m1_reg <= `SSCR_Z24;
            m2_reg <= `SSCR_Z24;
            m3_reg <= `SSCR_Z24;
            m4_reg <= `SSCR_Z24;
            m5_reg <= `SSCR_Z24;
            m6_reg <= `SSCR_Z24;
        end
        else if (take)
        begin
            m0_reg <= r0_reg;
            m1_reg <= r1_reg;
            m2_reg <= r2_reg;
            m3_reg <= r3_reg;
            m4_reg <= r4_reg;
            m5_reg <= r5_reg;
            m6_reg <= r6_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // decoded outputs

    logic builtin;
    logic [1:0] spur_code;
    logic [12:0] fb_div_next;
    logic [8:0] ref_div_next;

    assign builtin = m0_reg[`SSCR_R0_BUILTIN];
    assign spur_code = m1_reg[`SSCR_R1_SPUR_HI:`SSCR_R1_SPUR_LO];

    function automatic logic [12:0] fb_div(input logic [8:0] main_c,
                                          input logic [3:0] swal_c);
        fb_div = {main_c, 4'h0} + {9'h000, swal_c};
    endfunction

    always_comb
    begin
        if (builtin)
        begin
            fb_div_next = fb_div(`SSCR_DEF_MAIN, `SSCR_DEF_SWAL);
            ref_div_next = `SSCR_DEF_REF;
        end
        else
        begin
            fb_div_next = fb_div(m4_reg[`SSCR_R4_MAIN_HI:`SSCR_R4_MAIN_LO],
                                 m4_reg[`SSCR_R4_SWAL_HI:`SSCR_R4_SWAL_LO]);
            ref_div_next = m5_reg[`SSCR_R5_REF_HI:`SSCR_R5_REF_LO];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            synth_active_o <= 1'b0;
            aux_active_o <= 1'b0;
            out_buffer_power_o <= 2'h0;
            default_aux_freq_select_o <= 2'h0;
            reference_rate_select_o <= 1'b0;
            aux_pump_current_o <= 2'h0;
            boost_duration_o <= 2'h0;
            boost_phase_threshold_o <= 2'h0;
            boost_active_o <= 1'b0;
            oscillator_drive_current_o <= 2'h0;
            aux_feedback_div_o <= 13'h0000;
            aux_ref_div_o <= 9'h000;
            factory_test_o <= `SSCR_Z24;
        end
        else
        begin
            synth_active_o <= ce_sync_reg[1] & m1_reg[`SSCR_R1_SYNTH];
            aux_active_o <= ce_sync_reg[1] & m1_reg[`SSCR_R1_AUX];
            out_buffer_power_o <= m1_reg[`SSCR_R1_OBP_HI:`SSCR_R1_OBP_LO];
            default_aux_freq_select_o <=
                m1_reg[`SSCR_R1_AUXF_HI:`SSCR_R1_AUXF_LO];
            reference_rate_select_o <= m1_reg[`SSCR_R1_REFSEL];
            aux_pump_current_o <= m2_reg[`SSCR_R2_PUMP_HI:`SSCR_R2_PUMP_LO];
            boost_duration_o <= m3_reg[`SSCR_R3_DUR_HI:`SSCR_R3_DUR_LO];
            boost_phase_threshold_o <=
                m3_reg[`SSCR_R3_THR_HI:`SSCR_R3_THR_LO];
            boost_active_o <= m3_reg[`SSCR_R3_BOOST] & ~lock_sync_reg[1]
                              & ce_sync_reg[1];
            oscillator_drive_current_o <=
                m3_reg[`SSCR_R3_OSC_HI:`SSCR_R3_OSC_LO];
            aux_feedback_div_o <= fb_div_next;
            aux_ref_div_o <= ref_div_next;
            factory_test_o <= m6_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // spur scheme state

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            spur_mode_o <= SSCR_SP_OFF;
        else
        begin
            case (spur_code)
                `SSCR_SPUR_TRACK: spur_mode_o <= SSCR_SP_TRACK;
                `SSCR_SPUR_ONCE:
                begin
                    // adapt until lock rises, then stay frozen
                    if (lock_sync_reg[1] && !lock_d_reg)
                        spur_mode_o <= SSCR_SP_FROZEN;
                    else if (spur_mode_o != SSCR_SP_FROZEN)
                        spur_mode_o <= SSCR_SP_TRACK;
                end
                default: spur_mode_o <= SSCR_SP_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            spur_adapt_o <= 1'b0;
        else
            spur_adapt_o <= (spur_code == `SSCR_SPUR_TRACK) ||
                            ((spur_code == `SSCR_SPUR_ONCE) &&
                             (spur_mode_o != SSCR_SP_FROZEN) &&
                             !(lock_sync_reg[1] && !lock_d_reg));
        end
endmodule

/* File: dv/sscr_regs_asserts.sv */
module sscr_regs_asserts
(
    // clock and pins
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic latch_strobe_i,
    input wire logic chip_en_i,
    input wire logic pll_locked_i,
    // watched outputs
    input wire logic synth_active_o,
    input wire logic aux_active_o,
    input wire logic boost_active_o,
    input wire sscr_pkg::sscr_spur_t spur_mode_o,
    input wire logic spur_adapt_o,
    input wire logic [12:0] aux_feedback_div_o,
    input wire logic [8:0] aux_ref_div_o,
    input wire logic [23:0] factory_test_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sscr_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // strobe low long enough that no load is in flight
    sequence quiet_s;
        !latch_strobe_i [*8];
    endsequence
    ////////////////////////////////////////////////////
    a_ce_off_en: assert property (
        !chip_en_i [*4] |-> !synth_active_o && !aux_active_o)
        else $error("section on while chip off");
    a_ce_off_boost: assert property (
        !chip_en_i [*4] |-> !boost_active_o)
        else $error("boost on while chip off");
    a_synth_needs_ce: assert property (
        $rose(synth_active_o) |-> $past(chip_en_i, 3))
        else $error("synth rose without chip on");
    a_lock_stops_boost: assert property (
        pll_locked_i [*4] |-> !boost_active_o)
        else $error("boost on after lock");
    a_off_no_adapt: assert property (
        spur_mode_o == SSCR_SP_OFF |-> !spur_adapt_o)
        else $error("adapting with spur off");
    a_frozen_no_adapt: assert property (
        spur_mode_o == SSCR_SP_FROZEN |-> !spur_adapt_o)
        else $error("adapting while frozen");
    a_frozen_holds: assert property (
        quiet_s ##0 $past(spur_mode_o) == SSCR_SP_FROZEN
        |-> spur_mode_o == SSCR_SP_FROZEN)
        else $error("frozen mode left without load");
    a_words_stable: assert property (
        quiet_s |-> $stable(factory_test_o) && $stable(aux_ref_div_o)
        && $stable(aux_feedback_div_o))
        else $error("word changed without load");
    c_frozen: cover property (spur_mode_o == SSCR_SP_FROZEN);
    c_boost: cover property (boost_active_o);
    c_ce_off: cover property (!chip_en_i [*4]);
endmodule

bind sscr_regs sscr_regs_asserts u_chk (
    .clk_i, .rst_i, .latch_strobe_i, .chip_en_i, .pll_locked_i,
    .synth_active_o, .aux_active_o, .boost_active_o, .spur_mode_o,
    .spur_adapt_o, .aux_feedback_div_o, .aux_ref_div_o, .factory_test_o
);

/* File: dv/sscr_host_model.sv */
module sscr_host_model
(
    // serial link
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic latch_strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // link clock stands low between frames
    initial
    begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b0;
        latch_strobe_o = 1'b0;
    end
    task automatic tick();
        #6 ser_clk_o = 1'b1;
        #6 ser_clk_o = 1'b0;
    endtask
    ////////////////////////////////////////////////////
    // msb first, strobe rise loads
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            ser_data_o = w[i];
            tick();
        end
        latch_strobe_o = 1'b1;
        // data line driven to the inverse of the last bit during the load tick
        ser_data_o = ~w[0];
        tick();
        latch_strobe_o = 1'b0;
    endtask
endmodule

/* File: dv/testbench.sv */
`include "sscr_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sscr_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic chip_en_i = 1'b1;
    logic pll_locked_i = 1'b0;
    logic ser_clk_i, ser_data_i, latch_strobe_i;
    logic synth_active_o, aux_active_o, reference_rate_select_o;
    logic boost_active_o, spur_adapt_o;
    logic [1:0] out_buffer_power_o, default_aux_freq_select_o;
    logic [1:0] aux_pump_current_o, boost_duration_o;
    logic [1:0] boost_phase_threshold_o, oscillator_drive_current_o;
    sscr_spur_t spur_mode_o;
    logic [12:0] aux_feedback_div_o;
    logic [8:0] aux_ref_div_o;
    logic [23:0] factory_test_o;
    int bad_count = 0;
    int checked = 0;
    always #2 clk_i = ~clk_i;
    sscr_regs uut (
        .clk_i, .rst_i, .ser_clk_i, .ser_data_i, .latch_strobe_i,
        .chip_en_i, .pll_locked_i, .synth_active_o, .aux_active_o,
        .out_buffer_power_o, .default_aux_freq_select_o,
        .reference_rate_select_o, .aux_pump_current_o, .boost_duration_o,
        .boost_phase_threshold_o, .boost_active_o,
        .oscillator_drive_current_o, .spur_mode_o, .spur_adapt_o,
        .aux_feedback_div_o, .aux_ref_div_o, .factory_test_o
    );
    sscr_host_model host (.ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
        .latch_strobe_o(latch_strobe_i));
    ////////////////////////////////////////////////////
    task automatic cmp(input string n, input logic [23:0] e,
        input logic [23:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    // outputs settle within 6 clk of the load
    task automatic put(input logic [23:0] w);
        @(posedge clk_i);
        host.send(w);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wait8();
        repeat (8) @(posedge clk_i);
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////
    task automatic t_startup();
        put(24'h6DE8F3);
        put(24'hC9BA8A);
        put(24'hB0196D);
        put(24'h800000);
        cmp("dur", 2'b01, boost_duration_o);
        cmp("thr", 2'b10, boost_phase_threshold_o);
        cmp("osc", 2'b11, oscillator_drive_current_o);
        cmp("boost", 1'b1, boost_active_o);
        cmp("refsel", 1'b1, reference_rate_select_o);
        cmp("fb", {`SSCR_DEF_MAIN, 4'h0} + `SSCR_DEF_SWAL,
            aux_feedback_div_o);
        $display("test startup done");
    endtask
    task automatic t_codes();
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            put(24'h100141 | (24'(c) << 22) | (24'(c) << 11)
                | (24'(c) << 4) | (24'(c) << 2));
            put(24'h09BA8A | (24'(c) << 22));
            cmp("auxf", c, default_aux_freq_select_o);
            cmp("obp", c, out_buffer_power_o);
            cmp("synth", c[1], synth_active_o);
            cmp("aux", c[0], aux_active_o);
            cmp("mode", c[1] ? SSCR_SP_TRACK : SSCR_SP_OFF,
                spur_mode_o);
            cmp("adapt", c[1], spur_adapt_o);
            cmp("pump", c, aux_pump_current_o);
        end
        $display("test codes done");
    endtask
    task automatic t_lock();
        pll_locked_i <= 1'b1;
        wait8();
        cmp("mode", SSCR_SP_FROZEN, spur_mode_o);
        cmp("adapt", 1'b0, spur_adapt_o);
        cmp("boost", 1'b0, boost_active_o);
        pll_locked_i <= 1'b0;
        wait8();
        cmp("mode", SSCR_SP_FROZEN, spur_mode_o);
        $display("test lock done");
    endtask
    task automatic t_ce();
        chip_en_i <= 1'b0;
        wait8();
        cmp("synth", 1'b0, synth_active_o);
        cmp("aux", 1'b0, aux_active_o);
        cmp("boost", 1'b0, boost_active_o);
        chip_en_i <= 1'b1;
        wait8();
        cmp("synth", 1'b1, synth_active_o);
        $display("test chip enable done");
    endtask
    task automatic t_div();
        put(24'h80001F);
        put(24'h30BFEF);
        put(24'h11FFF7);
        cmp("ref", `SSCR_DEF_REF, aux_ref_div_o);
        put(24'h000000);
        cmp("fb", 13'h1FFF, aux_feedback_div_o);
        cmp("ref", 9'h1FF, aux_ref_div_o);
        cmp("test", 24'h80001F, factory_test_o);
        put(24'hFFFFFF);
        cmp("fb", 13'h1FFF, aux_feedback_div_o);
        put(24'h800000);
        cmp("ref", `SSCR_DEF_REF, aux_ref_div_o);
        $display("test dividers done");
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_startup();
        t_codes();
        t_lock();
        t_ce();
        t_div();
        end_sim();
    end
    // hang guard
    initial
    begin
        #40000;
        bad_count++;
        end_sim();
    end
endmodule
